// ### hvsb_ctrl.sv
// high-voltage string brightness, boost frequency and ramp control
//
// What this block does
// - per-sink feedback enable, default one
// - feedback enables arm shorted-string fault flag
// - bit zero picks 500 kHz or 1 MHz
// - bit three selects automatic frequency mode
// - auto: code msbs above threshold gives 1 MHz
// - auto: code msbs at or below gives 500 kHz
// - current from full scale, code, duty
// - ramps step through all eleven code bits
// - new code applied only on high write
// - pwm assignable per bank, linear duty
// - pwm polarity may be active low
// - bit three enables near-zero pwm detection
// - sixteen start-up and shutdown durations, shared
// - start-up to set point, shutdown to zero
// - sixteen run-time up and down durations
// - ramp select chooses run-time ramp source
// - one mapping mode shared by both banks
// - enable pin low resets every register
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
module hvsb_ctrl #(
    parameter int RAMP_UNIT_CYC = hvsb_pkg::RAMP_UNIT_CYC,
    parameter int ZERO_DET_CYC = hvsb_pkg::ZERO_DET_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hardware_enable_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic pwm_in,
    output logic boost_freq_1mhz,
    output logic [2:0] sink_fb_include,
    output logic [2:0] short_fault_arm,
    output logic [2:0] sink_bank_sel,
    output logic [10:0] bank_a_code,
    output logic [10:0] bank_b_code,
    output logic bank_a_duty,
    output logic bank_b_duty,
    output logic map_linear,
    output logic device_active
);

    ////////////////////////////////////////////////////////////////////////
    // reset release and shutdown

    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_int_n;
    logic clr;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_int_n = rst_s2_q;
    assign clr = !hardware_enable_pin;

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [2:0] fb_en_q;
    logic [2:0] bank_map_q;
    logic [7:0] boost_ctrl_q;
    logic [7:0] auto_thr_q;
    logic [7:0] pwm_cfg_q;
    logic [7:0] su_sd_q;
    logic [7:0] run_q;
    logic [7:0] ramp_map_q;
    logic [1:0] bank_en_q;
    logic [2:0] lsb_q [2];
    logic [10:0] code_q [2];

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr && reg_addr == ofs;
    endfunction

    // routing, feedback and boost configuration
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            fb_en_q <= hvsb_pkg::RST_FB_EN;
            bank_map_q <= hvsb_pkg::RST_BANK_MAP;
            boost_ctrl_q <= hvsb_pkg::RST_BOOST_CTRL;
            auto_thr_q <= hvsb_pkg::RST_AUTO_THR;
        end else if (clr) begin
            fb_en_q <= hvsb_pkg::RST_FB_EN;
            bank_map_q <= hvsb_pkg::RST_BANK_MAP;
            boost_ctrl_q <= hvsb_pkg::RST_BOOST_CTRL;
            auto_thr_q <= hvsb_pkg::RST_AUTO_THR;
        end else begin
            if (wr_hit(hvsb_pkg::OFS_FB_EN)) begin
                fb_en_q <= reg_wdata[2:0];
            end
            if (wr_hit(hvsb_pkg::OFS_BANK_MAP)) begin
                bank_map_q <= reg_wdata[2:0];
            end
            if (wr_hit(hvsb_pkg::OFS_BOOST_CTRL)) begin
                boost_ctrl_q <= reg_wdata;
            end
            if (wr_hit(hvsb_pkg::OFS_AUTO_THR)) begin
                auto_thr_q <= reg_wdata;
            end
        end
    end

    // pwm, ramp timing and mapping configuration
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pwm_cfg_q <= hvsb_pkg::RST_PWM_CFG;
            su_sd_q <= hvsb_pkg::RST_RAMP;
            run_q <= hvsb_pkg::RST_RAMP;
            ramp_map_q <= hvsb_pkg::RST_RAMP_MAP;
            bank_en_q <= hvsb_pkg::RST_BANK_EN;
        end else if (clr) begin
            pwm_cfg_q <= hvsb_pkg::RST_PWM_CFG;
            su_sd_q <= hvsb_pkg::RST_RAMP;
            run_q <= hvsb_pkg::RST_RAMP;
            ramp_map_q <= hvsb_pkg::RST_RAMP_MAP;
            bank_en_q <= hvsb_pkg::RST_BANK_EN;
        end else begin
            if (wr_hit(hvsb_pkg::OFS_PWM_CFG)) begin
                pwm_cfg_q <= reg_wdata;
            end
            if (wr_hit(hvsb_pkg::OFS_SU_SD_RAMP)) begin
                su_sd_q <= reg_wdata;
            end
            if (wr_hit(hvsb_pkg::OFS_RUN_RAMP)) begin
                run_q <= reg_wdata;
            end
            if (wr_hit(hvsb_pkg::OFS_RAMP_MAP)) begin
                ramp_map_q <= reg_wdata;
            end
            if (wr_hit(hvsb_pkg::OFS_BANK_EN)) begin
                bank_en_q <= reg_wdata[1:0];
            end
        end
    end

    // brightness: low bits are held, the high write applies both
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            lsb_q[0] <= '0;
            lsb_q[1] <= '0;
            code_q[0] <= '0;
            code_q[1] <= '0;
        end else if (clr) begin
            lsb_q[0] <= '0;
            lsb_q[1] <= '0;
            code_q[0] <= '0;
            code_q[1] <= '0;
        end else begin
            if (wr_hit(hvsb_pkg::OFS_A_LSB)) begin
                lsb_q[0] <= reg_wdata[2:0];
            end
            if (wr_hit(hvsb_pkg::OFS_B_LSB)) begin
                lsb_q[1] <= reg_wdata[2:0];
            end
            if (wr_hit(hvsb_pkg::OFS_A_MSB)) begin
                code_q[0] <= {reg_wdata, lsb_q[0]};
            end
            if (wr_hit(hvsb_pkg::OFS_B_MSB)) begin
                code_q[1] <= {reg_wdata, lsb_q[1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp durations

    function automatic logic [31:0] ramp_cycles(input logic [3:0] sel);
        ramp_cycles = (sel == 4'h0) ? 32'h0 : (32'(RAMP_UNIT_CYC) << sel);
    endfunction

    logic [31:0] su_cyc;
    logic [31:0] sd_cyc;
    logic [31:0] ru_cyc;
    logic [31:0] rd_cyc;

    assign su_cyc = ramp_cycles(su_sd_q[3:0]);
    assign sd_cyc = ramp_cycles(su_sd_q[7:4]);
    assign ru_cyc = ramp_cycles(run_q[3:0]);
    assign rd_cyc = ramp_cycles(run_q[7:4]);

    ////////////////////////////////////////////////////////////////////////
    // per-bank phase and ramp

    hvsb_pkg::hvsb_phase_t phase_q [2];
    logic [10:0] cur [2];
    logic busy [2];
    logic [10:0] target [2];
    logic [31:0] dur_up [2];
    logic [31:0] dur_dn [2];

    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clk_sys or negedge rst_int_n) begin
            if (!rst_int_n) begin
                phase_q[b] <= hvsb_pkg::PH_IDLE;
            end else if (clr) begin
                phase_q[b] <= hvsb_pkg::PH_IDLE;
            end else begin
                case (phase_q[b])
                    hvsb_pkg::PH_IDLE: begin
                        if (bank_en_q[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_STARTUP;
                        end
                    end
                    hvsb_pkg::PH_STARTUP: begin
                        if (!bank_en_q[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_SHUTDOWN;
                        end else if (!busy[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_RUN;
                        end
                    end
                    hvsb_pkg::PH_RUN: begin
                        if (!bank_en_q[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_SHUTDOWN;
                        end
                    end
                    hvsb_pkg::PH_SHUTDOWN: begin
                        if (bank_en_q[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_STARTUP;
                        end else if (!busy[b]) begin
                            phase_q[b] <= hvsb_pkg::PH_IDLE;
                        end
                    end
                    default: begin
                        phase_q[b] <= hvsb_pkg::PH_IDLE;
                    end
                endcase
            end
        end

        always_comb begin
            target[b] = bank_en_q[b] ? code_q[b] : 11'h000;
            dur_up[b] = su_cyc;
            dur_dn[b] = sd_cyc;
            if (phase_q[b] == hvsb_pkg::PH_RUN) begin
                case (ramp_map_q[1:0])
                    2'h0: begin
                        dur_up[b] = ru_cyc;
                        dur_dn[b] = rd_cyc;
                    end
                    2'h1: begin
                        dur_up[b] = su_cyc;
                        dur_dn[b] = sd_cyc;
                    end
                    default: begin
                        dur_up[b] = 32'h0;
                        dur_dn[b] = 32'h0;
                    end
                endcase
            end
        end

        hvsb_ramp #(
            .CODE_W(hvsb_pkg::CODE_W)
        ) u_ramp (
            .clk_sys(clk_sys),
            .rst_n(rst_int_n),
            .clr(clr),
            .target(target[b]),
            .dur_up(dur_up[b]),
            .dur_dn(dur_dn[b]),
            .cur_q(cur[b]),
            .busy(busy[b])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm input

    logic pwm_level;
    logic pwm_zero;

    hvsb_pwm #(
        .ZERO_CYC(ZERO_DET_CYC)
    ) u_pwm (
        .clk_sys(clk_sys),
        .rst_n(rst_int_n),
        .clr(clr),
        .pwm_in(pwm_in),
        .active_low(pwm_cfg_q[hvsb_pkg::BIT_PWM_LOW]),
        .zero_det_en(pwm_cfg_q[hvsb_pkg::BIT_ZERO_DET]),
        .pwm_level_q(pwm_level),
        .zero_q(pwm_zero)
    );

    logic pwm_eff;
    assign pwm_eff = pwm_level && !pwm_zero;

    ////////////////////////////////////////////////////////////////////////
    // boost frequency

    logic [7:0] msb_max;
    logic freq_d;

    assign msb_max = (cur[0][10:3] > cur[1][10:3]) ? cur[0][10:3] : cur[1][10:3];

    always_comb begin
        if (boost_ctrl_q[hvsb_pkg::BIT_AUTO_FREQ]) begin
            freq_d = msb_max > auto_thr_q;
        end else begin
            freq_d = boost_ctrl_q[hvsb_pkg::BIT_FREQ_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the analog side

    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            boost_freq_1mhz <= 1'b0;
            sink_fb_include <= '0;
            short_fault_arm <= '0;
            sink_bank_sel <= '0;
            bank_a_duty <= 1'b1;
            bank_b_duty <= 1'b1;
            map_linear <= 1'b0;
            device_active <= 1'b0;
        end else begin
            boost_freq_1mhz <= freq_d;
            sink_fb_include <= clr ? 3'h0 : fb_en_q;
            short_fault_arm <= clr ? 3'h0 : fb_en_q;
            sink_bank_sel <= bank_map_q;
            bank_a_duty <= pwm_cfg_q[hvsb_pkg::BIT_PWM_EN_A] ? pwm_eff : 1'b1;
            bank_b_duty <= pwm_cfg_q[hvsb_pkg::BIT_PWM_EN_B] ? pwm_eff : 1'b1;
            map_linear <= ramp_map_q[hvsb_pkg::BIT_MAP_LIN];
            device_active <= hardware_enable_pin;
        end
    end

    assign bank_a_code = cur[0];
    assign bank_b_code = cur[1];

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] rd_d;

    always_comb begin
        case (reg_addr)
            hvsb_pkg::OFS_FB_EN: rd_d = {5'h00, fb_en_q};
            hvsb_pkg::OFS_BANK_MAP: rd_d = {5'h00, bank_map_q};
            hvsb_pkg::OFS_BOOST_CTRL: rd_d = boost_ctrl_q;
            hvsb_pkg::OFS_AUTO_THR: rd_d = auto_thr_q;
            hvsb_pkg::OFS_PWM_CFG: rd_d = pwm_cfg_q;
            hvsb_pkg::OFS_SU_SD_RAMP: rd_d = su_sd_q;
            hvsb_pkg::OFS_RUN_RAMP: rd_d = run_q;
            hvsb_pkg::OFS_RAMP_MAP: rd_d = ramp_map_q;
            hvsb_pkg::OFS_BANK_EN: rd_d = {6'h00, bank_en_q};
            hvsb_pkg::OFS_A_LSB: rd_d = {5'h00, lsb_q[0]};
            hvsb_pkg::OFS_A_MSB: rd_d = code_q[0][10:3];
            hvsb_pkg::OFS_B_LSB: rd_d = {5'h00, lsb_q[1]};
            hvsb_pkg::OFS_B_MSB: rd_d = code_q[1][10:3];
            hvsb_pkg::OFS_STATUS: rd_d = {3'h0, busy[1], busy[0], pwm_zero, pwm_level, freq_d};
            hvsb_pkg::OFS_CUR_A: rd_d = cur[0][10:3];
            hvsb_pkg::OFS_CUR_B: rd_d = cur[1][10:3];
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_d : 8'h00;
        end
    end

endmodule // hvsb_ctrl

// ### hvsb_pkg.sv
// constants and types shared by the high-voltage string brightness control
package hvsb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CODE_W = 11;
    localparam int SINKS = 3;

    // register offsets
    localparam logic [7:0] OFS_FB_EN = 8'h00;
    localparam logic [7:0] OFS_BANK_MAP = 8'h01;
    localparam logic [7:0] OFS_BOOST_CTRL = 8'h02;
    localparam logic [7:0] OFS_AUTO_THR = 8'h03;
    localparam logic [7:0] OFS_PWM_CFG = 8'h04;
    localparam logic [7:0] OFS_SU_SD_RAMP = 8'h05;
    localparam logic [7:0] OFS_RUN_RAMP = 8'h06;
    localparam logic [7:0] OFS_RAMP_MAP = 8'h07;
    localparam logic [7:0] OFS_BANK_EN = 8'h08;
    localparam logic [7:0] OFS_A_LSB = 8'h09;
    localparam logic [7:0] OFS_A_MSB = 8'h0a;
    localparam logic [7:0] OFS_B_LSB = 8'h0b;
    localparam logic [7:0] OFS_B_MSB = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h0d;
    localparam logic [7:0] OFS_CUR_A = 8'h0e;
    localparam logic [7:0] OFS_CUR_B = 8'h0f;

    // field positions
    localparam int BIT_FREQ_SEL = 0;
    localparam int BIT_AUTO_FREQ = 3;
    localparam int BIT_PWM_EN_A = 0;
    localparam int BIT_PWM_EN_B = 1;
    localparam int BIT_PWM_LOW = 2;
    localparam int BIT_ZERO_DET = 3;
    localparam int BIT_MAP_LIN = 2;

    // values after reset
    localparam logic [2:0] RST_FB_EN = 3'h7;
    localparam logic [2:0] RST_BANK_MAP = 3'h0;
    localparam logic [7:0] RST_BOOST_CTRL = 8'h00;
    localparam logic [7:0] RST_AUTO_THR = 8'h6c;
    localparam logic [7:0] RST_PWM_CFG = 8'h00;
    localparam logic [7:0] RST_RAMP = 8'h00;
    localparam logic [7:0] RST_RAMP_MAP = 8'h00;
    localparam logic [1:0] RST_BANK_EN = 2'h0;
    localparam logic [7:0] RST_CODE = 8'h00;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int RAMP_UNIT_US = 2;
    localparam int RAMP_UNIT_CYC = RAMP_UNIT_US * CLK_MHZ;
    localparam int ZERO_DET_NS = 1000;
    localparam int ZERO_DET_CYC = (ZERO_DET_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_STARTUP,
        PH_RUN,
        PH_SHUTDOWN
    } hvsb_phase_t;

endpackage

// ### hvsb_ramp.sv
// one-count-per-step current ramp toward a target code, loaded at once when the duration is zero
`timescale 1ns/1ns
module hvsb_ramp #(
    parameter int CODE_W = 11
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic [CODE_W-1:0] target,
    input wire logic [31:0] dur_up,
    input wire logic [31:0] dur_dn,
    output logic [CODE_W-1:0] cur_q,
    output logic busy
);
    logic [CODE_W-1:0] tgt_q;
    logic [CODE_W-1:0] dist_q;
    logic [31:0] acc_q;
    logic up;
    logic [31:0] dur;
    logic [31:0] acc_sum;

    assign up = target > cur_q;
    assign dur = up ? dur_up : dur_dn;
    assign acc_sum = acc_q + 32'(dist_q);
    assign busy = cur_q != target;

    // distance-weighted accumulator spreads the steps over the duration
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '0;
            tgt_q <= '0;
            dist_q <= '0;
            acc_q <= '0;
        end else if (clr) begin
            cur_q <= '0;
            tgt_q <= '0;
            dist_q <= '0;
            acc_q <= '0;
        end else begin
            tgt_q <= target;
            if (target != tgt_q) begin
                dist_q <= up ? target - cur_q : cur_q - target;
                acc_q <= '0;
            end else if (!busy) begin
                acc_q <= '0;
            end else if (dur == 32'h0) begin
                cur_q <= target;
            end else if (acc_sum >= dur) begin
                acc_q <= acc_sum - dur;
                cur_q <= up ? cur_q + 1'b1 : cur_q - 1'b1;
            end else begin
                acc_q <= acc_sum;
            end
        end
    end
endmodule // hvsb_ramp

// ### hvsb_pwm.sv
// pwm input polarity and near-zero detection
`timescale 1ns/1ns
module hvsb_pwm #(
    parameter int ZERO_CYC = 100
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic pwm_in,
    input wire logic active_low,
    input wire logic zero_det_en,
    output logic pwm_level_q,
    output logic zero_q
);
    localparam int CW = $clog2(ZERO_CYC + 1);
    localparam logic [CW-1:0] LIMIT = CW'(ZERO_CYC);
    logic [CW-1:0] idle_cnt_q;
    logic level;

    assign level = pwm_in ^ active_low;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwm_level_q <= 1'b0;
            idle_cnt_q <= '0;
            zero_q <= 1'b0;
        end else if (clr) begin
            pwm_level_q <= 1'b0;
            idle_cnt_q <= '0;
            zero_q <= 1'b0;
        end else begin
            pwm_level_q <= level;
            if (level) begin
                idle_cnt_q <= '0;
            end else if (idle_cnt_q != LIMIT) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
            zero_q <= zero_det_en && !level && idle_cnt_q == LIMIT;
        end
    end
endmodule // hvsb_pwm

// ### hvsb_ctrl_sva.sv
// port-level assertions for the brightness control
`timescale 1ns/1ns
module hvsb_ctrl_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hardware_enable_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic pwm_in,
    input wire logic boost_freq_1mhz,
    input wire logic [2:0] sink_fb_include,
    input wire logic [2:0] short_fault_arm,
    input wire logic [10:0] bank_a_code,
    input wire logic [10:0] bank_b_code,
    input wire logic bank_a_duty,
    input wire logic map_linear,
    input wire logic device_active
);
    logic [7:0] sh_q [0:8];
    logic [2:0] age_q;
    logic [7:0] mx;
    logic slow;
    assign mx = (bank_a_code[10:3] > bank_b_code[10:3]) ? bank_a_code[10:3] : bank_b_code[10:3];
    assign slow = sh_q[5][3:0] != 4'h0 && sh_q[5][7:4] != 4'h0 && sh_q[6][3:0] != 4'h0
        && sh_q[6][7:4] != 4'h0 && !sh_q[7][1];
    // shadow of the writable registers at offsets 0x00 to 0x08
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n || !hardware_enable_pin) begin
            for (int i = 0; i < 9; i++) begin
                sh_q[i] <= (i == 0) ? 8'h07 : (i == 3) ? 8'h6c : 8'h00;
            end
        end else if (reg_wr && reg_addr < 8'h09) begin
            sh_q[reg_addr] <= reg_wdata;
        end
    end
    // cycles since the last write or clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n || !hardware_enable_pin || reg_wr) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_fb;
        age_q > 3'h3 |-> sink_fb_include == sh_q[0][2:0] && short_fault_arm == sink_fb_include;
    endproperty
    a_fb: assert property (p_fb)
        else $error("feedback outputs wrong");
    property p_freq;
        age_q > 3'h3 && !sh_q[2][3] |-> boost_freq_1mhz == sh_q[2][0];
    endproperty
    a_freq: assert property (p_freq)
        else $error("fixed frequency wrong");
    property p_auto;
        age_q > 3'h3 && sh_q[2][3] && $stable(bank_a_code) && $stable(bank_b_code)
            |-> boost_freq_1mhz == (mx > sh_q[3]);
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto frequency wrong");
    property p_pwm;
        age_q > 3'h3 && sh_q[4][0] && !sh_q[4][3]
            |-> bank_a_duty == ($past(pwm_in, 2) ^ sh_q[4][2]);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("duty gating wrong");
    property p_map;
        age_q > 3'h3 |-> map_linear == sh_q[7][2];
    endproperty
    a_map: assert property (p_map)
        else $error("mapping mode wrong");
    property p_hw;
        !hardware_enable_pin [*2] |=> sink_fb_include == 3'h0 && !device_active
            && bank_a_code == 11'h0;
    endproperty
    a_hw: assert property (p_hw)
        else $error("enable pin clear missing");
    property p_shut;
        $fell(sh_q[8][0]) && sh_q[5][7:4] == 4'h0 |-> ##[1:8] bank_a_code == 11'h0;
    endproperty
    a_shut: assert property (p_shut)
        else $error("shutdown did not reach zero");
    property p_step;
        age_q > 3'h3 && slow |-> bank_a_code == $past(bank_a_code)
            || bank_a_code == $past(bank_a_code) + 11'h1 || bank_a_code + 11'h1 == $past(bank_a_code);
    endproperty
    a_step: assert property (p_step)
        else $error("ramp step above one");
endmodule // hvsb_ctrl_chk
bind hvsb_ctrl hvsb_ctrl_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .hardware_enable_pin(hardware_enable_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .pwm_in(pwm_in), .boost_freq_1mhz(boost_freq_1mhz),
    .sink_fb_include(sink_fb_include), .short_fault_arm(short_fault_arm),
    .bank_a_code(bank_a_code), .bank_b_code(bank_b_code), .bank_a_duty(bank_a_duty),
    .map_linear(map_linear), .device_active(device_active));

// ### hvsb_host_pwm.sv
// pwm source standing in for the host
`timescale 1ns/1ns
module hvsb_host_pwm (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [15:0] hi_cyc,
    input wire logic [15:0] lo_cyc,
    output logic pwm_in
);
    logic [15:0] cnt_q;
    // period within 2 to 100 kHz, pulses far above the zero-detect minimum
    always @(posedge clk_sys) begin
        if (!run) begin
            cnt_q <= 16'h0;
            pwm_in <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == hi_cyc + lo_cyc - 16'h1) ? 16'h0 : cnt_q + 16'h1;
            pwm_in <= cnt_q < hi_cyc;
        end
    end
endmodule // hvsb_host_pwm

// ### hvsb_ctrl_test.sv
// self-checking bench for the brightness control
`timescale 1ns/1ns
module hvsb_ctrl_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hw = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic [15:0] hi = 16'd250;
    logic [15:0] lo = 16'd750;
    logic pwm_in, freq, da, db, lin, act, saw;
    logic [7:0] rdata;
    logic [2:0] fb, arm, sel;
    logic [10:0] ca, cb;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    hvsb_ctrl #(.RAMP_UNIT_CYC(1), .ZERO_DET_CYC(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .hardware_enable_pin(hw), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .pwm_in(pwm_in), .boost_freq_1mhz(freq),
        .sink_fb_include(fb), .short_fault_arm(arm), .sink_bank_sel(sel), .bank_a_code(ca),
        .bank_b_code(cb), .bank_a_duty(da), .bank_b_duty(db), .map_linear(lin),
        .device_active(act));
    hvsb_host_pwm host_u (.clk_sys(clk_sys), .run(run), .hi_cyc(hi), .lo_cyc(lo), .pwm_in(pwm_in));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_a(input logic [10:0] t);
        int n;
        n = 0;
        saw = 1'b0;
        while (ca !== t && n < 3000) begin
            cyc(1);
            saw |= ca == 11'd12;
            n++;
        end
        chk(ca, t);
    endtask
    task automatic duty(input logic [7:0] cfg, input int ea, input int eb);
        logic [15:0] na, nb;
        na = 0;
        nb = 0;
        wr(8'h04, cfg);
        cyc(4);
        repeat (1000) begin
            cyc(1);
            na += da;
            nb += db;
        end
        chk(na, ea);
        chk(nb, eb);
    endtask
    ////////////////////////////////////////
    task automatic t_reg();
        rd(8'h00, 8'h07);
        rd(8'h03, 8'h6c);
        rd(8'h20, 8'h00);
        chk(arm, 3'h7);
        wr(8'h01, 8'h06);
        wr(8'h00, 8'h05);
        cyc(3);
        chk(fb, 3'h5);
        chk(arm, 3'h5);
        chk(sel, 3'h6);
        wr(8'h07, 8'h04);
        cyc(3);
        chk(lin, 1'b1);
        wr(8'h02, 8'h01);
        cyc(3);
        chk(freq, 1'b1);
        wr(8'h02, 8'h00);
        cyc(3);
        chk(freq, 1'b0);
    endtask
    task automatic t_code();
        wr(8'h08, 8'h01);
        wr(8'h09, 8'h05);
        cyc(4);
        chk(ca, 11'h0);
        wr(8'h0a, 8'h80);
        cyc(4);
        chk(ca, 11'h405);
        rd(8'h0e, 8'h80);
        wr(8'h02, 8'h09);
        wr(8'h0a, 8'h6c);
        cyc(4);
        chk(freq, 1'b0);
        wr(8'h0a, 8'h6d);
        cyc(4);
        chk(freq, 1'b1);
        wr(8'h03, 8'h70);
        wr(8'h08, 8'h03);
        wr(8'h0c, 8'h71);
        cyc(4);
        chk(freq, 1'b1);
        wr(8'h02, 8'h00);
    endtask
    task automatic t_ramp();
        wr(8'h07, 8'h02);
        wr(8'h09, 8'h00);
        wr(8'h0a, 8'h01);
        cyc(4);
        chk(ca, 11'd8);
        wr(8'h07, 8'h00);
        wr(8'h05, 8'h11);
        wr(8'h06, 8'h11);
        wr(8'h0a, 8'h02);
        cyc(3);
        chk(ca < 11'd16, 1'b1);
        wait_a(11'd16);
        chk(saw, 1'b1);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h01);
        wr(8'h0a, 8'h04);
        cyc(3);
        chk(ca < 11'd32, 1'b1);
        wait_a(11'd32);
        wr(8'h05, 8'h01);
        wr(8'h08, 8'h02);
        cyc(6);
        chk(ca, 11'h0);
        wr(8'h08, 8'h03);
        cyc(3);
        chk(ca < 11'd32, 1'b1);
        wait_a(11'd32);
        wr(8'h05, 8'h11);
        wr(8'h08, 8'h02);
        cyc(3);
        chk(ca > 11'd0, 1'b1);
        wait_a(11'h0);
    endtask
    task automatic t_pwm();
        @(posedge clk_sys);
        run <= 1'b1;
        duty(8'h01, 250, 1000);
        duty(8'h05, 750, 1000);
        duty(8'h02, 1000, 250);
        wr(8'h04, 8'h09);
        @(posedge clk_sys);
        run <= 1'b0;
        cyc(10);
        rd(8'h0d, 8'h04);
    endtask
    task automatic t_hw();
        @(posedge clk_sys);
        hw <= 1'b0;
        cyc(3);
        chk(act, 1'b0);
        chk(fb, 3'h0);
        wr(8'h00, 8'h02);
        @(posedge clk_sys);
        hw <= 1'b1;
        cyc(4);
        rd(8'h00, 8'h07);
        rd(8'h04, 8'h00);
        chk(cb, 11'h0);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(4);
        t_reg();
        t_code();
        t_ramp();
        t_pwm();
        t_hw();
        print_verdict();
    end
endmodule // hvsb_ctrl_test
